/* File: verilog/ieafa_pkg.sv */
// constants for the isochronous endpoint fifo allocator
package ieafa_pkg;
  localparam int SYS_CLK_MHZ = 100;
  localparam int SYS_CLK_PERIOD_NS = 10;
  localparam int CORE_CLK_MHZ = 24;
  localparam int CORE_CLKS_PER_MCYC = 4;
  localparam int FAST_MCYCS = 2;
  localparam int FAST_CORE_CLKS = FAST_MCYCS * CORE_CLKS_PER_MCYC;
  localparam int STROBE_FIRST = 2;
  localparam int STROBE_LAST = 5;
  localparam int FRAME_PERIOD_NS = 1000000;
  localparam int FRAME_PERIOD_CYC = FRAME_PERIOD_NS / SYS_CLK_PERIOD_NS;
  localparam int NUM_EP = 16;
  localparam int NUM_OUT_EP = 8;
  localparam int FIFO_BYTES = 1024;
  localparam int ADDR_W = 10;
  localparam int COUNT_W = 10;
  localparam int GRAN_SHIFT = 4;
  // register byte offsets
  localparam logic [5:0] OFS_BASE = 6'h00;
  localparam logic [5:0] OFS_DATA = 6'h10;
  localparam logic [5:0] OFS_OUT_COUNT = 6'h20;
  localparam logic [5:0] OFS_CRC_STATUS = 6'h30;
  localparam logic [5:0] OFS_FRAME_FLAG = 6'h31;
  localparam logic [5:0] OFS_FAST_CTRL = 6'h32;
  // fields of fast_transfer_control, the frame flag register and the start registers
  localparam int FAST_ISO_BIT = 7;
  localparam int READ_POL_BIT = 5;
  localparam int WRITE_POL_BIT = 2;
  localparam int FRAME_FLAG_BIT = 0;
  localparam int BASE_LSB = 2;
  // reset values
  localparam logic [5:0] BASE_RESET = 6'h00;
  localparam logic [7:0] FAST_CTRL_RESET = 8'h00;
endpackage

/* File: verilog/ieafa_top.sv */
// isochronous endpoint fifo subsystem with shared double-buffered ram
`timescale 1ns/10ps
`default_nettype none
// Contract
// [RULE1] present OUT fifos with 10-bit counts each frame
// [RULE2] firmware drains OUT data within 1 ms
// [RULE3] frame flag cleared by writing one
// [RULE4] per-endpoint CRC error bit in status register
// [RULE5] bad-CRC data still delivered into fifo
// [RULE6] sixteen endpoints share one 1024-byte ram
// [RULE7] start register bits 7:2 give A9..A4
// [RULE8] base address has four zero LSBs
// [RULE9] size is four times start register difference
// [RULE10] firmware writes start values with LSBs clear
// [RULE11] start registers consecutive, OUT8..15 then IN8..15
// [RULE12] firmware avoids overlapping regions, unchecked
// [RULE13] one data register per OUT endpoint
// [RULE14] fast mode routes data port bytes externally
// [RULE15] fast access moves one byte, one strobe
// [RULE16] machine cycle is four 24 MHz clocks
// [RULE17] data register is fifo head or tail
// [RULE18] halves swap at every start-of-frame
// [RULE19] internal frame timer covers missed SOF
// [RULE20] strobe polarity bits: zero low, one high
// [RULE21] pointers stay inside their allocated region
module ieafa_top
  import ieafa_pkg::*;
#(
  parameter int FRAME_CYC = FRAME_PERIOD_CYC
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [5:0] cpu_addr,
  input wire logic cpu_rd,
  input wire logic cpu_wr,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  input wire logic usb_sof,
  input wire logic usb_out_wr,
  input wire logic [2:0] usb_out_ep,
  input wire logic [7:0] usb_out_byte,
  input wire logic usb_out_end,
  input wire logic usb_out_crc_bad,
  input wire logic usb_in_rd,
  input wire logic [2:0] usb_in_ep,
  output logic [7:0] usb_in_byte,
  output logic [COUNT_W-1:0] usb_in_count,
  input wire logic [7:0] ext_d_in,
  output logic [7:0] ext_d_out,
  output logic ext_d_oe,
  output logic ext_rd_strobe,
  output logic ext_wr_strobe,
  output logic fast_busy,
  output logic frame_irq_request_flag,
  output logic usb_shared_interrupt
);
  localparam int FT_W = $clog2(FRAME_CYC + 1);
  typedef enum logic {IEAFA_IDLE, IEAFA_RUN} ieafa_state_t;

  logic [7:0] mem [2*FIFO_BYTES];
  logic [5:0] base_reg [NUM_EP];
  logic [ADDR_W-1:0] cpu_ptr_reg [NUM_EP];
  logic [ADDR_W-1:0] usb_ptr_reg [NUM_EP];
  logic [COUNT_W-1:0] out_count_reg [NUM_OUT_EP];
  logic [COUNT_W-1:0] in_count_reg [NUM_OUT_EP];
  logic [10:0] ep_size [NUM_EP];
  logic [ADDR_W-1:0] ep_base [NUM_EP];
  logic [7:0] crc_pend_reg, crc_stat_reg, fast_ctrl_reg;
  logic bank_reg;
  logic [FT_W-1:0] frame_cnt_reg;
  logic frame_evt;
  logic [6:0] core_acc_reg;
  logic core_en;
  logic [7:0] d_meta_reg, d_sync_reg;
  ieafa_state_t fast_state_reg;
  logic [3:0] fast_cnt_reg;
  logic [3:0] fast_ep_reg;
  logic fast_push_reg;
  logic dp_hit, fast_on, cpu_pop, cpu_push, fast_start, fast_sample;
  logic adv_go, adv_ok, strobe_act, out_ok, in_ok;
  logic [3:0] cpu_ep, adv_ep, in_idx;
  logic [ADDR_W-1:0] adv_addr;

  // base is A9..A4 with four zero bits; size follows the next start
  always_comb begin
    for (int e = 0; e < NUM_EP; e++) begin
      ep_base[e] = {base_reg[e], 4'h0}; // see [RULE8]
      if (e < NUM_EP - 1) begin
        ep_size[e] = {1'b0, base_reg[e+1], 4'h0} - {1'b0, base_reg[e], 4'h0}; // see [RULE9]
      end else begin
        ep_size[e] = 11'h400 - {1'b0, base_reg[e], 4'h0}; // see [RULE9]
      end
    end
  end

  // frame events: real SOF or the fallback timer
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      frame_cnt_reg <= '0;
    end else if (usb_sof || frame_evt) begin
      frame_cnt_reg <= '0;
    end else begin
      frame_cnt_reg <= frame_cnt_reg + 1'b1;
    end
  end
  // timer fires one frame after the last event so frames keep coming
  assign frame_evt = usb_sof || (frame_cnt_reg == FT_W'(FRAME_CYC - 1)); // see [RULE19]

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      bank_reg <= 1'b0;
    end else if (frame_evt) begin
      bank_reg <= ~bank_reg; // see [RULE18]
    end
  end

  // 24 MHz core clock enable from a fractional accumulator
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      core_acc_reg <= '0;
    end else if (core_en) begin
      core_acc_reg <= 7'(core_acc_reg + 7'(CORE_CLK_MHZ) - 7'(SYS_CLK_MHZ));
    end else begin
      core_acc_reg <= 7'(core_acc_reg + 7'(CORE_CLK_MHZ));
    end
  end
  assign core_en = (core_acc_reg + 7'(CORE_CLK_MHZ)) >= 7'(SYS_CLK_MHZ); // see [RULE16]

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      d_meta_reg <= '0;
      d_sync_reg <= '0;
    end else begin
      d_meta_reg <= ext_d_in;
      d_sync_reg <= d_meta_reg;
    end
  end

  assign dp_hit = (cpu_addr[5:4] == OFS_DATA[5:4]);
  assign cpu_ep = cpu_addr[3:0];
  assign fast_on = fast_ctrl_reg[FAST_ISO_BIT];
  // accesses in the swap cycle or during a fast move are dropped
  assign cpu_pop = cpu_rd && dp_hit && !fast_on && !fast_busy && !frame_evt;
  assign cpu_push = cpu_wr && dp_hit && !fast_on && !fast_busy && !frame_evt;
  assign fast_start = (cpu_rd || cpu_wr) && dp_hit && fast_on && !fast_busy && !frame_evt; // see [RULE14]
  assign fast_sample = (fast_state_reg == IEAFA_RUN) && core_en && fast_push_reg
                       && (fast_cnt_reg == 4'(STROBE_LAST));

  always_comb begin
    adv_go = 1'b0;
    adv_ep = cpu_ep;
    if (fast_sample) begin
      adv_go = !frame_evt;
      adv_ep = fast_ep_reg;
    end else if (cpu_pop || cpu_push || (fast_start && cpu_rd)) begin
      adv_go = 1'b1;
    end
  end
  assign adv_ok = {1'b0, cpu_ptr_reg[adv_ep]} < ep_size[adv_ep]; // see [RULE21]
  assign adv_addr = ADDR_W'(ep_base[adv_ep] + cpu_ptr_reg[adv_ep]);

  assign in_idx = {1'b1, usb_in_ep};
  assign out_ok = {1'b0, usb_ptr_reg[{1'b0, usb_out_ep}]} < ep_size[{1'b0, usb_out_ep}];
  assign in_ok = ({1'b0, usb_ptr_reg[in_idx]} < ep_size[in_idx])
                 && (usb_ptr_reg[in_idx] < in_count_reg[usb_in_ep]);

  // single ram, cpu owns bank_reg half, usb owns the other
  always_ff @(posedge clk_sys) begin
    if (usb_out_wr && out_ok && !frame_evt) begin
      mem[{~bank_reg, ADDR_W'(ep_base[{1'b0, usb_out_ep}]
           + usb_ptr_reg[{1'b0, usb_out_ep}])}] <= usb_out_byte; // see [RULE5] [RULE6]
    end
    if ((cpu_push || (fast_sample && !frame_evt)) && adv_ok) begin
      mem[{bank_reg, adv_addr}] <= cpu_push ? cpu_wdata : d_sync_reg; // see [RULE17]
    end
  end

  // each access moves the fifo head or tail by one byte
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int e = 0; e < NUM_EP; e++) begin
        cpu_ptr_reg[e] <= '0;
      end
    end else if (frame_evt) begin
      for (int e = 0; e < NUM_EP; e++) begin
        cpu_ptr_reg[e] <= '0; // see [RULE2]
      end
    end else if (adv_go && adv_ok) begin
      cpu_ptr_reg[adv_ep] <= cpu_ptr_reg[adv_ep] + 1'b1; // see [RULE17] [RULE21]
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int e = 0; e < NUM_EP; e++) begin
        usb_ptr_reg[e] <= '0;
      end
    end else if (frame_evt) begin
      for (int e = 0; e < NUM_EP; e++) begin
        usb_ptr_reg[e] <= '0;
      end
    end else begin
      if (usb_out_wr && out_ok) begin
        usb_ptr_reg[{1'b0, usb_out_ep}] <= usb_ptr_reg[{1'b0, usb_out_ep}] + 1'b1;
      end
      if (usb_in_rd && in_ok) begin
        usb_ptr_reg[in_idx] <= usb_ptr_reg[in_idx] + 1'b1;
      end
    end
  end

  // byte counts latched at the swap for both directions
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int k = 0; k < NUM_OUT_EP; k++) begin
        out_count_reg[k] <= '0;
        in_count_reg[k] <= '0;
      end
    end else if (frame_evt) begin
      for (int k = 0; k < NUM_OUT_EP; k++) begin
        out_count_reg[k] <= usb_ptr_reg[k]; // see [RULE1]
        in_count_reg[k] <= cpu_ptr_reg[k + NUM_OUT_EP];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      usb_in_byte <= '0;
      usb_in_count <= '0;
    end else begin
      usb_in_count <= in_count_reg[usb_in_ep];
      if (usb_in_rd && in_ok && !frame_evt) begin
        usb_in_byte <= mem[{~bank_reg, ADDR_W'(ep_base[in_idx] + usb_ptr_reg[in_idx])}];
      end
    end
  end

  // an error late in the swap cycle still lands in the next status
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      crc_pend_reg <= '0;
      crc_stat_reg <= '0;
    end else if (frame_evt) begin
      crc_stat_reg <= crc_pend_reg; // see [RULE4]
      crc_pend_reg <= (usb_out_end && usb_out_crc_bad) ? (8'h01 << usb_out_ep) : 8'h00;
    end else if (usb_out_end && usb_out_crc_bad) begin
      crc_pend_reg[usb_out_ep] <= 1'b1; // see [RULE4]
    end
  end

  // start registers at consecutive offsets, low two bits not stored
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int e = 0; e < NUM_EP; e++) begin
        base_reg[e] <= BASE_RESET;
      end
      fast_ctrl_reg <= FAST_CTRL_RESET;
    end else if (cpu_wr) begin
      if (cpu_addr[5:4] == OFS_BASE[5:4]) begin
        base_reg[cpu_ep] <= cpu_wdata[7:BASE_LSB]; // see [RULE7] [RULE11]
      end
      if (cpu_addr == OFS_FAST_CTRL) begin
        fast_ctrl_reg <= cpu_wdata;
      end
    end
  end

  // set wins over a simultaneous one-write clear
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      frame_irq_request_flag <= 1'b0;
      usb_shared_interrupt <= 1'b0;
    end else begin
      if (frame_evt) begin
        frame_irq_request_flag <= 1'b1;
      end else if (cpu_wr && cpu_addr == OFS_FRAME_FLAG && cpu_wdata[FRAME_FLAG_BIT]) begin
        frame_irq_request_flag <= 1'b0; // see [RULE3]
      end
      usb_shared_interrupt <= frame_irq_request_flag || frame_evt;
    end
  end

  // register read port, one cycle latency
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cpu_rdata <= '0;
    end else if (cpu_rd) begin
      case (cpu_addr[5:4])
        OFS_BASE[5:4]: cpu_rdata <= {base_reg[cpu_ep], 2'b00}; // see [RULE7]
        OFS_DATA[5:4]: cpu_rdata <= (adv_ok && !frame_evt && !fast_busy)
                                    ? mem[{bank_reg, adv_addr}] : 8'h00; // see [RULE13]
        OFS_OUT_COUNT[5:4]: cpu_rdata <= cpu_addr[0]
            ? {6'h00, out_count_reg[cpu_addr[3:1]][9:8]}
            : out_count_reg[cpu_addr[3:1]][7:0]; // see [RULE1]
        default: begin
          if (cpu_addr == OFS_CRC_STATUS) begin
            cpu_rdata <= crc_stat_reg;
          end else if (cpu_addr == OFS_FRAME_FLAG) begin
            cpu_rdata <= {7'h00, frame_irq_request_flag};
          end else if (cpu_addr == OFS_FAST_CTRL) begin
            cpu_rdata <= fast_ctrl_reg;
          end else begin
            cpu_rdata <= 8'h00;
          end
        end
      endcase
    end
  end

  // fast move: two machine cycles of four core clocks, one strobe
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      fast_state_reg <= IEAFA_IDLE;
      fast_cnt_reg <= '0;
      fast_ep_reg <= '0;
      fast_push_reg <= 1'b0;
    end else begin
      case (fast_state_reg)
        IEAFA_IDLE: begin
          if (fast_start) begin
            fast_state_reg <= IEAFA_RUN;
            fast_cnt_reg <= '0;
            fast_ep_reg <= cpu_ep;
            fast_push_reg <= cpu_wr; // see [RULE15]
          end
        end
        IEAFA_RUN: begin
          if (core_en) begin
            if (fast_cnt_reg == 4'(FAST_CORE_CLKS - 1)) begin
              fast_state_reg <= IEAFA_IDLE; // see [RULE15]
            end
            fast_cnt_reg <= fast_cnt_reg + 1'b1;
          end
        end
        default: fast_state_reg <= IEAFA_IDLE;
      endcase
    end
  end

  assign strobe_act = (fast_state_reg == IEAFA_RUN)
                      && (fast_cnt_reg >= 4'(STROBE_FIRST))
                      && (fast_cnt_reg <= 4'(STROBE_LAST));

  // polarity is applied in the flop so the pins never glitch
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ext_rd_strobe <= 1'b1;
      ext_wr_strobe <= 1'b1;
      ext_d_out <= '0;
      ext_d_oe <= 1'b0;
      fast_busy <= 1'b0;
    end else begin
      ext_rd_strobe <= ~((strobe_act && fast_push_reg) ^ fast_ctrl_reg[READ_POL_BIT]); // see [RULE20]
      ext_wr_strobe <= ~((strobe_act && !fast_push_reg) ^ fast_ctrl_reg[WRITE_POL_BIT]); // see [RULE20]
      fast_busy <= fast_start || ((fast_state_reg == IEAFA_RUN)
                   && !(core_en && fast_cnt_reg == 4'(FAST_CORE_CLKS - 1)));
      if (fast_start && cpu_rd) begin
        ext_d_out <= adv_ok ? mem[{bank_reg, adv_addr}] : 8'h00; // see [RULE14]
        ext_d_oe <= 1'b1;
      end else if (fast_state_reg == IEAFA_RUN && core_en
                   && fast_cnt_reg == 4'(FAST_CORE_CLKS - 1)) begin
        ext_d_oe <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/ieafa_chk.sv */
// port-level assertions for the iso fifo allocator
`timescale 1ns/10ps
`default_nettype none
module ieafa_chk
  import ieafa_pkg::*;
#(
  parameter int FRAME_CYC = FRAME_PERIOD_CYC
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [5:0] cpu_addr,
  input wire logic cpu_rd,
  input wire logic cpu_wr,
  input wire logic [7:0] cpu_wdata,
  input wire logic [7:0] cpu_rdata,
  input wire logic usb_sof,
  input wire logic ext_d_oe,
  input wire logic ext_rd_strobe,
  input wire logic ext_wr_strobe,
  input wire logic fast_busy,
  input wire logic frame_irq_request_flag,
  input wire logic usb_shared_interrupt
);
  logic [7:0] ctrl_reg;
  logic act_reg;
  logic [2:0] strb_reg;
  wire logic act = (ext_rd_strobe == ctrl_reg[READ_POL_BIT]) ||
    (ext_wr_strobe == ctrl_reg[WRITE_POL_BIT]);
  wire logic dport = cpu_addr[5:4] == 2'b01;
  int fcnt_reg;
  // shadow of the fallback timer, so frames it makes are known here as well
  wire logic fevt = usb_sof || (fcnt_reg == FRAME_CYC - 1);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  // shadow copy, so enable and polarity are known without peeking inside
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) ctrl_reg <= FAST_CTRL_RESET;
    else if (cpu_wr && cpu_addr == OFS_FAST_CTRL) ctrl_reg <= cpu_wdata;
  end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) fcnt_reg <= 0;
    else if (fevt) fcnt_reg <= 0;
    else fcnt_reg <= fcnt_reg + 1;
  end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      act_reg <= 1'b0;
      strb_reg <= 3'h0;
    end else begin
      act_reg <= act;
      if ($rose(fast_busy)) strb_reg <= 3'h0;
      else if (act && !act_reg) strb_reg <= strb_reg + 3'h1;
    end
  end
  sequence s_busy_hold;
    fast_busy [*8];
  endsequence
  sequence s_strobe_on;
    ##[1:14] act;
  endsequence
  flag_set_a: assert property (fevt |=> frame_irq_request_flag)
    else $error("frame flag not set by frame event");
  flag_clear_a: assert property (cpu_wr && cpu_addr == OFS_FRAME_FLAG &&
    cpu_wdata[FRAME_FLAG_BIT] && !fevt |=> !frame_irq_request_flag)
    else $error("frame flag not cleared by one-write");
  irq_mirror_a: assert property (frame_irq_request_flag |=> usb_shared_interrupt)
    else $error("shared interrupt does not follow flag");
  base_lsb_a: assert property (cpu_rd && cpu_addr[5:4] == 2'b00 |=>
    cpu_rdata[1:0] == 2'h0)
    else $error("start register low bits not zero");
  fast_start_a: assert property (cpu_rd && dport && ctrl_reg[FAST_ISO_BIT] &&
    !fast_busy && !fevt |=> fast_busy && ext_d_oe)
    else $error("fast read did not start");
  oe_busy_a: assert property (ext_d_oe |-> fast_busy)
    else $error("bus driven outside a fast move");
  busy_len_a: assert property ($rose(fast_busy) |->
    s_busy_hold ##[20:40] !fast_busy)
    else $error("fast move length wrong");
  strobe_on_a: assert property ($rose(fast_busy) |-> s_strobe_on)
    else $error("no strobe in fast move");
  one_strobe_a: assert property ($fell(fast_busy) |-> strb_reg == 3'h1)
    else $error("strobe count per move not one");
  strobe_idle_a: assert property (!fast_busy && !$past(fast_busy) &&
    $stable(ctrl_reg) |-> ext_rd_strobe == !ctrl_reg[READ_POL_BIT] &&
    ext_wr_strobe == !ctrl_reg[WRITE_POL_BIT])
    else $error("idle strobe level wrong");
endmodule
bind ieafa_top ieafa_chk #(.FRAME_CYC(FRAME_CYC)) u_chk (
  .clk_sys(clk_sys), .resetn(resetn), .cpu_addr(cpu_addr), .cpu_rd(cpu_rd),
  .cpu_wr(cpu_wr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .usb_sof(usb_sof),
  .ext_d_oe(ext_d_oe), .ext_rd_strobe(ext_rd_strobe), .ext_wr_strobe(ext_wr_strobe),
  .fast_busy(fast_busy), .frame_irq_request_flag(frame_irq_request_flag),
  .usb_shared_interrupt(usb_shared_interrupt)
);
`default_nettype wire

/* File: tb/ieafa_host_model.sv */
// usb host side: frame marks, iso out packets and in pops
`timescale 1ns/10ps
`default_nettype none
module ieafa_host_model (
  input wire logic clk_sys,
  output logic usb_sof,
  output logic usb_out_wr,
  output logic [2:0] usb_out_ep,
  output logic [7:0] usb_out_byte,
  output logic usb_out_end,
  output logic usb_out_crc_bad,
  output logic usb_in_rd,
  output logic [2:0] usb_in_ep,
  input wire logic [7:0] usb_in_byte
);
  initial begin
    {usb_sof, usb_out_wr, usb_out_end, usb_out_crc_bad, usb_in_rd} = 5'h0;
    usb_out_ep = 3'h0;
    usb_out_byte = 8'h00;
    usb_in_ep = 3'h0;
  end
  task automatic sof();
    @(posedge clk_sys);
    usb_sof <= 1'b1;
    @(posedge clk_sys);
    usb_sof <= 1'b0;
  endtask
  // bytes count up from first; the verdict travels with the end mark
  task automatic out_pkt(input logic [2:0] ep, input int n, input logic bad,
    input logic [7:0] first);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      usb_out_wr <= 1'b1;
      usb_out_ep <= ep;
      usb_out_byte <= first + 8'(i);
    end
    @(posedge clk_sys);
    usb_out_wr <= 1'b0;
    usb_out_byte <= ~usb_out_byte;
    usb_out_end <= 1'b1;
    usb_out_crc_bad <= bad;
    @(posedge clk_sys);
    usb_out_end <= 1'b0;
    usb_out_crc_bad <= ~bad;
  endtask
  task automatic in_pop(input logic [2:0] ep, output logic [7:0] b);
    @(posedge clk_sys);
    usb_in_rd <= 1'b1;
    usb_in_ep <= ep;
    @(posedge clk_sys);
    usb_in_rd <= 1'b0;
    #1;
    b = usb_in_byte;
  endtask
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench for the iso fifo allocator
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import ieafa_pkg::*;
  ;
  localparam int FCYC = 400;
  typedef struct packed {logic wr; logic [5:0] addr; logic [7:0] data; logic [7:0] exp;} ieafa_row_t;
  logic clk_sys, resetn, cpu_rd, cpu_wr, drv;
  logic [5:0] cpu_addr;
  logic [7:0] cpu_wdata, cpu_rdata, ext_d_in, ext_d_out, usb_in_byte, usb_out_byte;
  logic usb_sof, usb_out_wr, usb_out_end, usb_out_crc_bad, usb_in_rd;
  logic [2:0] usb_out_ep, usb_in_ep;
  logic [COUNT_W-1:0] usb_in_count;
  logic ext_d_oe, ext_rd_strobe, ext_wr_strobe, fast_busy;
  logic frame_irq_request_flag, usb_shared_interrupt;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  ieafa_row_t rows [13] = '{'{1'b0, 6'h01, 8'h00, 8'h04}, '{1'b0, 6'h08, 8'h00, 8'h08},
    '{1'b0, 6'h0F, 8'h00, 8'h0C}, '{1'b1, 6'h0E, 8'hFF, 8'h00}, '{1'b0, 6'h0E, 8'h00, 8'hFC},
    '{1'b1, 6'h0E, 8'h0C, 8'h00}, '{1'b1, 6'h3F, 8'hFF, 8'h00}, '{1'b0, 6'h3F, 8'h00, 8'h00},
    '{1'b1, 6'h30, 8'hFF, 8'h00}, '{1'b0, 6'h30, 8'h00, 8'h00}, '{1'b1, 6'h32, 8'h24, 8'h00},
    '{1'b0, 6'h32, 8'h00, 8'h24}, '{1'b1, 6'h32, 8'h00, 8'h00}};
  ieafa_top #(.FRAME_CYC(FCYC)) DUT (.clk_sys(clk_sys), .resetn(resetn),
    .cpu_addr(cpu_addr), .cpu_rd(cpu_rd), .cpu_wr(cpu_wr), .cpu_wdata(cpu_wdata),
    .cpu_rdata(cpu_rdata), .usb_sof(usb_sof), .usb_out_wr(usb_out_wr),
    .usb_out_ep(usb_out_ep), .usb_out_byte(usb_out_byte), .usb_out_end(usb_out_end),
    .usb_out_crc_bad(usb_out_crc_bad), .usb_in_rd(usb_in_rd), .usb_in_ep(usb_in_ep),
    .usb_in_byte(usb_in_byte), .usb_in_count(usb_in_count), .ext_d_in(ext_d_in),
    .ext_d_out(ext_d_out), .ext_d_oe(ext_d_oe), .ext_rd_strobe(ext_rd_strobe),
    .ext_wr_strobe(ext_wr_strobe), .fast_busy(fast_busy),
    .frame_irq_request_flag(frame_irq_request_flag),
    .usb_shared_interrupt(usb_shared_interrupt));
  ieafa_host_model host (.clk_sys(clk_sys), .usb_sof(usb_sof), .usb_out_wr(usb_out_wr),
    .usb_out_ep(usb_out_ep), .usb_out_byte(usb_out_byte), .usb_out_end(usb_out_end),
    .usb_out_crc_bad(usb_out_crc_bad), .usb_in_rd(usb_in_rd), .usb_in_ep(usb_in_ep),
    .usb_in_byte(usb_in_byte));
  always #(SYS_CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;
  // wire level: our byte while the block drives, else the outside source or a toggle
  always @(posedge clk_sys) ext_d_in <= ext_d_oe ? ext_d_out : drv ? 8'h5A : ~ext_d_in;
  task automatic print_verdict();
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic chk_cnt(input logic [9:0] g, input logic [9:0] e);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    chk_cnt({2'h0, g}, {2'h0, e});
  endtask
  task automatic chk_bit(input logic g, input logic e);
    chk_cnt({9'h0, g}, {9'h0, e});
  endtask
  task automatic acc(input logic wr, input logic [5:0] a, input logic [7:0] d,
    output logic [7:0] q);
    @(posedge clk_sys);
    cpu_addr <= a;
    cpu_wdata <= d;
    if (wr) cpu_wr <= 1'b1;
    else cpu_rd <= 1'b1;
    @(posedge clk_sys);
    cpu_wr <= 1'b0;
    cpu_rd <= 1'b0;
    #1;
    q = cpu_rdata;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] q;
    acc(1'b0, a, 8'h00, q);
    chk_byte(q, e);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    acc(1'b1, a, d, q);
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 60 && fast_busy === 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    chk_bit(fast_busy, 1'b0);
  endtask
  // out8 16 B, out9 16 B, in8 16 B, in15 takes the rest
  function automatic logic [7:0] base_of(input int i);
    return i == 0 ? 8'h00 : i == 1 ? 8'h04 : i < 9 ? 8'h08 : 8'h0C;
  endfunction
  initial begin
    logic [7:0] b;
    clk_sys = 1'b0;
    resetn = 1'b0;
    {cpu_rd, cpu_wr, drv} = 3'h0;
    cpu_addr = 6'h00;
    cpu_wdata = 8'h00;
    ext_d_in = 8'h00;
    repeat (20) @(posedge clk_sys);
    chk_bit(ext_rd_strobe, 1'b1);
    chk_bit(frame_irq_request_flag, 1'b0);
    resetn <= 1'b1;
    rd(6'h00, 8'h00);
    rd(OFS_FAST_CTRL, FAST_CTRL_RESET);
    for (int i = 0; i < NUM_EP; i++) wr(6'(i), base_of(i));
    foreach (rows[i]) begin
      acc(rows[i].wr, rows[i].addr, rows[i].data, b);
      if (!rows[i].wr) chk_byte(b, rows[i].exp);
    end
    host.sof();
    host.out_pkt(3'h0, 3, 1'b1, 8'h10);
    host.out_pkt(3'h1, 20, 1'b0, 8'h40);
    wr(6'h18, 8'hA1);
    wr(6'h18, 8'hA2);
    host.sof();
    rd(6'h20, 8'h03);
    rd(6'h21, 8'h00);
    rd(6'h22, 8'h10);
    rd(OFS_CRC_STATUS, 8'h01);
    for (int i = 0; i < 3; i++) rd(6'h10, 8'h10 + 8'(i));
    for (int i = 0; i < 15; i++) rd(6'h11, 8'h40 + 8'(i));
    chk_bit(usb_shared_interrupt, 1'b1);
    wr(OFS_FRAME_FLAG, 8'h01);
    chk_bit(frame_irq_request_flag, 1'b0);
    chk_cnt(usb_in_count, 10'h002);
    host.in_pop(3'h0, b);
    chk_byte(b, 8'hA1);
    host.in_pop(3'h0, b);
    chk_byte(b, 8'hA2);
    wr(OFS_FAST_CTRL, 8'hA0);
    drv <= 1'b1;
    wr(6'h18, 8'h00);
    chk_bit(fast_busy, 1'b1);
    wait_idle();
    drv <= 1'b0;
    acc(1'b0, 6'h11, 8'h00, b);
    chk_byte(ext_d_out, 8'h4F);
    chk_bit(ext_d_oe, 1'b1);
    wait_idle();
    wr(OFS_FAST_CTRL, 8'h00);
    rd(6'h11, 8'h00);
    host.sof();
    rd(6'h20, 8'h00);
    chk_cnt(usb_in_count, 10'h001);
    host.in_pop(3'h0, b);
    chk_byte(b, 8'h5A);
    wr(OFS_FRAME_FLAG, 8'h01);
    repeat (FCYC + 4) @(posedge clk_sys);
    #1;
    chk_bit(frame_irq_request_flag, 1'b1);
    wr(6'h03, 8'h10);
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(6'h03, 8'h00);
    print_verdict();
  end
endmodule
`default_nettype wire
